// ---- src/gen_if.sv ----
// Control and data bundle between the control block and the generator core
`timescale 1ns/1ps
interface gen_if;
	logic tick;
	logic on;
	logic prbs_sel;
	logic [1:0] divide;
	logic invert;
	logic data;
	modport ctrl (output tick, output on, output prbs_sel, output divide, output invert, input data);
	modport core (input tick, input on, input prbs_sel, input divide, input invert, output data);
endinterface : gen_if

// ---- src/prbs_check_gen_control.sv ----
// Pattern checker and generator control with register file
`timescale 1ns/1ps
// Behaviour
// RULE_01: Checker sample phase 0/90/180/270 by field.
// RULE_02: Invert bit complements data into checker.
// RULE_03: Timer prescale is 4 shifted by code. Codes above 9 use the code 9 prescale.
// RULE_04: Interval count times prescale sets run length. An interval of 0 runs for one prescale period.
// RULE_05: Mode bit: 0 continuous, 1 timed.
// RULE_06: Host writes start 1 to begin run.
// RULE_07: Host clearing start acknowledges the result.
// RULE_08: Lock loss aborts run, then awaits acknowledge.
// RULE_09: Generator runs only while enable bit set.
// RULE_10: Generator never overrides sleep, mute, disable.
// RULE_11: Select bit: 1 PRBS7, 0 divided clock.
// RULE_12: Source 0 oscillator, 3 recovered, others reserved.
// RULE_13: Divided clock ratio 2, 4, 8, 16.
// RULE_14: Generator invert bit complements output.
// RULE_15: Host keeps reserved bits unchanged on write.
// RULE_16: Rate field 1..4 sets rate off recovered.
// RULE_17: Recovered source or lock forces loop rate.
// RULE_18: PRBS7 x^7+x^6+1; checker counts mismatches.
module prbs_check_gen_control (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	input wire logic [3:0] i_rx_phase,
	input wire logic i_cdr_locked,
	input wire logic [2:0] i_cdr_rate,
	input wire logic i_vco_tick,
	input wire logic i_rec_tick,
	input wire logic i_out_suppressed,
	output logic o_chk_running,
	output logic o_chk_done,
	output logic o_gen_data,
	output logic o_gen_drive,
	output logic [2:0] o_gen_rate
);
	import prbs_ctl_pkg::*;

	typedef struct packed {
		logic [15:0] chk_cfg;
		logic [15:0] chk_ctrl;
		logic [15:0] gen_ctrl;
		chk_state_t st;
		logic [10:0] pre_cnt;
		logic [7:0] int_cnt;
		logic [6:0] chk_sr;
		logic chk_bit;
		logic chk_bit_ok;
		logic [15:0] err_cnt;
		logic aborted;
		logic [15:0] rdata;
		logic [2:0] rate;
		logic drive;
		logic running;
		logic done;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t next_s;
	gen_if gif ();

	logic [1:0] phase;
	logic [3:0] pre_code;
	logic [10:0] pre_lim;
	logic pre_tick;
	logic timed;
	logic start;
	logic counting;
	logic mismatch;
	logic [1:0] src;
	logic [2:0] rate_field;

	prbs_gen_core u_gen (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.g(gif)
	);

	function automatic logic [10:0] prescale_limit(input logic [3:0] code);
		logic [3:0] c;
		c = (code > PRESCALE_MAX_CODE) ? PRESCALE_MAX_CODE : code;
		return (PRESCALE_BASE << c) - 11'h001;
	endfunction : prescale_limit

	always_comb begin
		phase = s.chk_cfg[PHASE_LSB +: 2];
		pre_code = s.chk_cfg[PRESCALE_LSB +: 4];
		pre_lim = prescale_limit(pre_code); // RULE_03
		pre_tick = (s.st == CHK_RUN) && (s.pre_cnt == pre_lim);
		timed = s.chk_ctrl[TIMED_BIT];
		start = s.chk_ctrl[START_BIT];
		src = s.gen_ctrl[GEN_SRC_LSB +: 2];
		rate_field = s.gen_ctrl[GEN_RATE_LSB +: 3];
		// Continuous mode counts whenever locked; timed only inside a run
		counting = timed ? (s.st == CHK_RUN) : i_cdr_locked; // RULE_05
		mismatch = s.chk_bit_ok && (s.chk_bit != (s.chk_sr[6] ^ s.chk_sr[5])); // RULE_18
	end

	always_comb begin
		next_s = s;
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				ADDR_CHK_CFG: next_s.chk_cfg = i_reg_wdata;
				ADDR_CHK_CTRL: next_s.chk_ctrl = i_reg_wdata;
				ADDR_GEN_CTRL: next_s.gen_ctrl = i_reg_wdata;
				ADDR_ERR_COUNT: next_s.err_cnt = 16'h0000;
				default: ;
			endcase
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				ADDR_CHK_CFG: next_s.rdata = s.chk_cfg;
				ADDR_CHK_CTRL: next_s.rdata = s.chk_ctrl;
				ADDR_GEN_CTRL: next_s.rdata = s.gen_ctrl;
				ADDR_ERR_COUNT: next_s.rdata = s.err_cnt;
				ADDR_CHK_STATUS: next_s.rdata = {12'h000, i_cdr_locked, s.aborted,
					s.st == CHK_WAIT_ACK, s.st == CHK_RUN};
				default: next_s.rdata = 16'h0000;
			endcase
		end

		// Checker front end
		next_s.chk_bit = i_rx_phase[phase] ^ s.chk_cfg[CHK_INV_BIT]; // RULE_01 RULE_02
		next_s.chk_sr = {s.chk_sr[5:0], s.chk_bit};
		next_s.chk_bit_ok = 1'b1;
		// Error counter saturates and does not wrap
		if (counting && mismatch && (s.err_cnt != 16'hffff)) begin // RULE_18
			next_s.err_cnt = s.err_cnt + 16'h0001;
		end

		unique case (s.st)
			CHK_IDLE: begin
				if (timed && start) begin // RULE_06 RULE_05
					next_s.st = CHK_RUN;
					next_s.pre_cnt = 11'h000;
					next_s.int_cnt = s.chk_cfg[INTERVAL_LSB +: 8];
					next_s.err_cnt = 16'h0000;
					next_s.aborted = 1'b0;
				end
			end
			CHK_RUN: begin
				if (!i_cdr_locked) begin // RULE_08
					next_s.st = CHK_WAIT_ACK;
					next_s.aborted = 1'b1;
				end else if (!start) begin
					next_s.st = CHK_IDLE;
				end else if (pre_tick) begin
					next_s.pre_cnt = 11'h000;
					// Interval of zero ends after one prescale period
					if (s.int_cnt <= 8'h01) begin // RULE_04
						next_s.st = CHK_WAIT_ACK;
					end else begin
						next_s.int_cnt = s.int_cnt - 8'h01;
					end
				end else begin
					next_s.pre_cnt = s.pre_cnt + 11'h001;
				end
			end
			CHK_WAIT_ACK: begin
				if (!start) begin // RULE_07
					next_s.st = CHK_IDLE;
				end
			end
			default: next_s.st = CHK_IDLE;
		endcase

		// Reserved rate codes leave the last good rate in place
		if ((src == SRC_RECOVERED) || i_cdr_locked) begin // RULE_17
			next_s.rate = i_cdr_rate;
		end else if ((rate_field >= RATE_MIN) && (rate_field <= RATE_MAX)) begin // RULE_16
			next_s.rate = rate_field;
		end
		// Sleep, mute and disable logic outside still gates the driver
		next_s.drive = s.gen_ctrl[GEN_ON_BIT] && !i_out_suppressed; // RULE_10
		// Status copies registered so the pins come straight off flops
		next_s.running = (next_s.st == CHK_RUN);
		next_s.done = (next_s.st == CHK_WAIT_ACK);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '{chk_cfg: CHK_CFG_RST, chk_ctrl: CHK_CTRL_RST, gen_ctrl: GEN_CTRL_RST,
				st: CHK_IDLE, pre_cnt: 11'h000, int_cnt: 8'h00, chk_sr: 7'h00,
				chk_bit: 1'b0, chk_bit_ok: 1'b0, err_cnt: 16'h0000, aborted: 1'b0,
				rdata: 16'h0000, rate: GEN_RATE_RST, drive: 1'b0, running: 1'b0, done: 1'b0};
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	always_comb begin
		gif.on = s.gen_ctrl[GEN_ON_BIT]; // RULE_09
		gif.prbs_sel = s.gen_ctrl[GEN_SEL_BIT];
		gif.divide = s.gen_ctrl[GEN_DIV_LSB +: 2];
		gif.invert = s.gen_ctrl[GEN_INV_BIT];
		// Reserved sources give no ticks, so the generator stalls
		gif.tick = ((src == SRC_VCO) && i_vco_tick) || ((src == SRC_RECOVERED) && i_rec_tick); // RULE_12
	end

	assign o_reg_rdata = s.rdata;
	assign o_chk_running = s.running;
	assign o_chk_done = s.done;
	assign o_gen_data = gif.data;
	assign o_gen_drive = s.drive;
	assign o_gen_rate = s.rate;

	sequence s_run_last_tick;
		i_ce && s.st == CHK_RUN && i_cdr_locked && start && pre_tick && s.int_cnt <= 8'h01;
	endsequence

	sequence s_enters_wait;
		s.st == CHK_WAIT_ACK && !s.aborted;
	endsequence

	a_phase_select: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_01
		(i_ce && !s.chk_cfg[CHK_INV_BIT] && !i_reg_wr) |=> (s.chk_bit == $past(i_rx_phase[phase])))
		else $error("checker phase sample wrong");

	a_check_invert: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_02
		(i_ce && s.chk_cfg[CHK_INV_BIT] && !i_reg_wr) |=> (s.chk_bit == !$past(i_rx_phase[phase])))
		else $error("checker inversion wrong");

	a_prescale_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_03
		(s.st == CHK_RUN) |-> (s.pre_cnt <= pre_lim))
		else $error("prescale counter passed its limit");

	a_run_end: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_04
		s_run_last_tick |=> s_enters_wait) else $error("timed run did not end on last interval");

	a_mode_timed: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_05
		$rose(o_chk_running) |-> $past(timed) && $past(start)) else $error("run began outside timed mode");

	a_ack_release: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_07
		(i_ce && s.st == CHK_WAIT_ACK && !start) |=> (s.st == CHK_IDLE)) else $error("acknowledge ignored");

	a_lock_abort: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_08
		(i_ce && s.st == CHK_RUN && !i_cdr_locked) |=> (o_chk_done && s.aborted) ##1 (s.aborted || !start))
		else $error("lock loss did not abort run");

	a_rate_forced: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_17
		(i_ce && (src == SRC_RECOVERED || i_cdr_locked)) |=> (o_gen_rate == $past(i_cdr_rate)))
		else $error("generator rate not taken from loop");

	a_rate_field: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_16
		(i_ce && src == SRC_VCO && !i_cdr_locked && rate_field >= RATE_MIN && rate_field <= RATE_MAX)
		|=> (o_gen_rate == $past(rate_field))) else $error("generator rate field ignored");
endmodule : prbs_check_gen_control

// ---- src/prbs_ctl_pkg.sv ----
// Constants and types shared by the pattern checker and generator control
package prbs_ctl_pkg;
	localparam logic [7:0] ADDR_CHK_CFG = 8'h50;
	localparam logic [7:0] ADDR_CHK_CTRL = 8'h51;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h52;
	localparam logic [7:0] ADDR_ERR_COUNT = 8'h5e;
	localparam logic [7:0] ADDR_CHK_STATUS = 8'h5f;

	localparam logic [15:0] CHK_CFG_RST = 16'h0003;
	localparam logic [15:0] CHK_CTRL_RST = 16'h0000;
	// Rate field comes up on a reserved code, so the effective rate holds its own reset
	localparam logic [15:0] GEN_CTRL_RST = 16'h0106;
	localparam logic [2:0] GEN_RATE_RST = 3'h0;

	// Field positions
	localparam int PHASE_LSB = 13;
	localparam int CHK_INV_BIT = 12;
	localparam int PRESCALE_LSB = 8;
	localparam int INTERVAL_LSB = 0;
	localparam int TIMED_BIT = 8;
	localparam int START_BIT = 0;
	localparam int GEN_ON_BIT = 9;
	localparam int GEN_SEL_BIT = 8;
	localparam int GEN_SRC_LSB = 6;
	localparam int GEN_DIV_LSB = 4;
	localparam int GEN_INV_BIT = 3;
	localparam int GEN_RATE_LSB = 0;

	localparam logic [1:0] SRC_VCO = 2'h0;
	localparam logic [1:0] SRC_RECOVERED = 2'h3;
	localparam logic [3:0] PRESCALE_MAX_CODE = 4'h9;
	localparam logic [10:0] PRESCALE_BASE = 11'h004;
	localparam logic [2:0] RATE_MIN = 3'h1;
	localparam logic [2:0] RATE_MAX = 3'h4;

	typedef enum logic [1:0] {CHK_IDLE, CHK_RUN, CHK_WAIT_ACK} chk_state_t;
endpackage : prbs_ctl_pkg

// ---- src/prbs_gen_core.sv ----
// Pattern generator core: PRBS7 or divided source clock
`timescale 1ns/1ps
module prbs_gen_core (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	gen_if.core g
);
	import prbs_ctl_pkg::*;

	typedef struct packed {
		logic [6:0] lfsr;
		logic [3:0] div_cnt;
		logic data;
	} gen_state_t;

	gen_state_t s;
	gen_state_t next_s;
	logic fb;

	always_comb begin
		next_s = s;
		fb = s.lfsr[6] ^ s.lfsr[5];
		if (!g.on) begin // RULE_09
			next_s.data = 1'b0;
		end else if (g.tick) begin
			next_s.lfsr = {s.lfsr[5:0], fb}; // RULE_18
			next_s.div_cnt = s.div_cnt + 4'h1;
			if (g.prbs_sel) begin // RULE_11
				next_s.data = fb ^ g.invert; // RULE_14
			end else begin
				// Bit d of the counter has period 2^(d+1) ticks
				next_s.data = next_s.div_cnt[g.divide] ^ g.invert; // RULE_13
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '{lfsr: 7'h7f, div_cnt: 4'h0, data: 1'b0};
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign g.data = s.data;

	a_gen_off_low: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_09
		(i_ce && !g.on) |=> !s.data) else $error("generator output not low while off");

	a_gen_invert: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_14
		(i_ce && g.on && g.tick && g.prbs_sel) |=> (s.data == ($past(fb) ^ $past(g.invert))))
		else $error("generator sense wrong");
endmodule : prbs_gen_core

// ---- verif/host_model.sv ----
// Host model driving the register port
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [15:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 16'h0000;
	end
	// Callers pass reserved bits as zero, their reset value
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge i_clk);
		o_wr = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge i_clk);
		o_rd = 1'b1;
		o_addr = a;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = ~a;
	endtask : rd
endmodule : host_model

// ---- verif/prbs_check_gen_control_tb.sv ----
// Self-checking bench for the checker and generator control
`timescale 1ns/1ps
module prbs_check_gen_control_tb;
	logic clk = 1'b0, rst_b = 1'b0, lock = 1'b0, vt = 1'b0, rt = 1'b0;
	logic sup = 1'b0, feed = 1'b0, finv = 1'b0, rd_seen = 1'b0, ce = 1'b1, s;
	logic wr, rd, run, done, gdata, drive;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	logic [3:0] rx = 4'h0, noise;
	logic [2:0] crate = 3'h2, rate;
	logic [1:0] fph = 2'h0;
	logic [6:0] lf = 7'h7f;
	logic [31:0] v, rv;
	logic [31:0] q[$];
	int seed = 32'h23a36e8a, bad_count = 0, check_count = 0, t;
	initial forever #25 clk = ~clk;
	host_model host_u (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	prbs_check_gen_control dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_phase(rx), .i_cdr_locked(lock),
		.i_cdr_rate(crate), .i_vco_tick(vt), .i_rec_tick(rt), .i_out_suppressed(sup), .o_chk_running(run),
		.o_chk_done(done), .o_gen_data(gdata), .o_gen_drive(drive), .o_gen_rate(rate));
	// Unused phases carry noise so a wrong phase pick shows up as errors
	always @(negedge clk) begin
		noise = 4'($random(seed));
		if (feed) begin
			lf <= {lf[5:0], lf[6] ^ lf[5]};
			noise[fph] = lf[6] ^ lf[5] ^ finv;
		end
		rx <= noise;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge clk) rd_seen <= rd;
	always @(negedge clk) begin
		if (rd_seen) begin
			v = q.pop_front();
			check(rdata & v[31:16], v[15:0]);
		end
	end
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		q.push_back({m, e});
		host_u.rd(a);
	endtask : rdchk
	task automatic tend(input string n);
		$display("test %s finished", n);
	endtask : tend
	task automatic tick(input logic rec);
		@(negedge clk);
		if (rec)
			rt = 1'b1;
		else
			vt = 1'b1;
		@(negedge clk);
		rt = 1'b0;
		vt = 1'b0;
		@(negedge clk);
	endtask : tick
	task automatic prbs(input logic [15:0] cfg, input logic rec, input logic inv);
		logic b[20];
		int ones;
		host_u.wr(8'h52, cfg | {12'h000, inv, 3'h0});
		ones = 0;
		for (int n = 0; n < 20; n++) begin
			tick(rec);
			b[n] = gdata;
			ones += int'(gdata);
		end
		for (int n = 7; n < 20; n++) check(16'(b[n]), 16'(b[n-6] ^ b[n-7] ^ inv));
		// A stuck output also meets the recurrence, so both levels must show
		check(16'(ones > 0 && ones < 20), 16'h1);
	endtask : prbs
	task automatic timed(input logic [15:0] cfg, input int len);
		int n;
		host_u.wr(8'h50, cfg);
		host_u.wr(8'h51, 16'h0101);
		repeat (2) @(negedge clk);
		check(16'(run), 16'h1);
		n = 2;
		while (done !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		check(16'(n >= len && n <= len + 4), 16'h1);
		host_u.wr(8'h51, 16'h0100);
		repeat (2) @(negedge clk);
		check(16'({run, done}), 16'h0);
	endtask : timed
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		lock = 1'b1;
		rdchk(8'h50, 16'h0003, 16'hffff);
		rdchk(8'h51, 16'h0000, 16'hffff);
		rdchk(8'h52, 16'h0106, 16'hffff);
		rdchk(8'h40, 16'h0000, 16'hffff);
		for (int i = 0; i < 4; i++) begin
			rv = $random(seed);
			host_u.wr(8'h50, rv[15:0] & 16'h7fff);
			rdchk(8'h50, rv[15:0] & 16'h7fff, 16'hffff);
		end
		tend("registers");
		host_u.wr(8'h51, 16'h0001);
		repeat (4) @(negedge clk);
		check(16'({run, done}), 16'h0);
		timed(16'h0003, 12);
		timed(16'h0100, 8);
		timed(16'h0901, 2048);
		host_u.wr(8'h50, 16'h0905);
		host_u.wr(8'h51, 16'h0101);
		repeat (30) @(negedge clk);
		lock = 1'b0;
		repeat (3) @(negedge clk);
		check(16'({run, done}), 16'h1);
		rdchk(8'h5f, 16'h0006, 16'h0006);
		host_u.wr(8'h51, 16'h0000);
		lock = 1'b1;
		repeat (2) @(negedge clk);
		check(16'(done), 16'h0);
		tend("timed");
		feed = 1'b1;
		for (int p = 0; p < 4; p++) begin
			fph = 2'(p);
			finv = p[0];
			host_u.wr(8'h50, {1'b0, 2'(p), finv, 12'h003});
			repeat (20) @(negedge clk);
			host_u.wr(8'h5e, 16'h0000);
			repeat (40) @(negedge clk);
			rdchk(8'h5e, 16'h0000, 16'hffff);
		end
		feed = 1'b0;
		tend("checker");
		prbs(16'h0300, 1'b0, 1'b0);
		prbs(16'h0300, 1'b0, 1'b1);
		prbs(16'h03c0, 1'b1, 1'b0);
		for (int d = 0; d < 5; d++) begin
			host_u.wr(8'h52, (d < 4) ? {8'h02, 2'b00, 2'(d), 4'h0} : 16'h0340);
			tick(1'b0);
			t = 0;
			for (int k = 0; k < 32; k++) begin
				s = gdata;
				tick(1'b0);
				t += int'(gdata != s);
			end
			check(16'(t), (d < 4) ? 16'(32 >> d) : 16'h0);
		end
		sup = 1'b1;
		repeat (3) @(negedge clk);
		check(16'(drive), 16'h0);
		sup = 1'b0;
		repeat (3) @(negedge clk);
		check(16'(drive), 16'h1);
		host_u.wr(8'h52, 16'h0100);
		repeat (3) @(negedge clk);
		check(16'({drive, gdata}), 16'h0);
		lock = 1'b0;
		for (int r = 1; r < 5; r++) begin
			host_u.wr(8'h52, 16'(r));
			repeat (2) @(negedge clk);
			check(16'(rate), 16'(r));
		end
		host_u.wr(8'h52, 16'h0006);
		repeat (2) @(negedge clk);
		check(16'(rate), 16'h0004);
		host_u.wr(8'h52, 16'h00c1);
		repeat (2) @(negedge clk);
		check(16'(rate), 16'(crate));
		host_u.wr(8'h52, 16'h0001);
		lock = 1'b1;
		repeat (2) @(negedge clk);
		check(16'(rate), 16'(crate));
		// Writes must be lost while the clock enable is low
		ce = 1'b0;
		host_u.wr(8'h52, 16'h0300);
		ce = 1'b1;
		rdchk(8'h52, 16'h0001, 16'hffff);
		tend("generator");
		final_report();
	end
	initial begin
		// About 20,000 cycles, several times the longest expected run
		#1000000;
		bad_count++;
		final_report();
	end
endmodule : prbs_check_gen_control_tb
